/* bench/fccg_pin_watch.sv */
// Circuit on the generator pins: edge times and phase widths per pin.
// Assumes i_mark is high on the edge that takes a sync command.
module fccg_pin_watch (
  input  wire logic             i_core_clk,
  input  wire logic             i_mark,
  input  wire logic [3:0]       i_pins,
  output logic      [3:0][15:0] o_high,
  output logic      [3:0][15:0] o_low,
  output logic      [3:0][15:0] o_first
);
  logic [15:0]      now_reg;
  logic [3:0][15:0] last_reg;
  logic [3:0]       seen_reg;
  logic [3:0]       prev_reg;
  logic             mark_d_reg;

  // Widths between edges; first edge time kept for phase comparisons
  always_ff @(posedge i_core_clk) begin
    now_reg <= i_mark ? 16'h0000 : now_reg + 16'h0001;
    prev_reg <= i_pins;
    mark_d_reg <= i_mark;
    if (i_mark) begin
      seen_reg <= 4'h0;
      last_reg <= '0;
    end
    for (int i = 0; i < 4; i++) begin
      // Preset edge lands one cycle after the mark; not a waveform edge
      if (!i_mark && !mark_d_reg && i_pins[i] !== prev_reg[i]) begin
        if (!seen_reg[i]) o_first[i] <= now_reg;
        seen_reg[i] <= 1'b1;
        if (prev_reg[i]) o_high[i] <= now_reg - last_reg[i];
        else o_low[i] <= now_reg - last_reg[i];
        last_reg[i] <= now_reg;
      end
    end
  end
endmodule : fccg_pin_watch

/* bench/fccg_top_chk.sv */
// Concurrent checks on the generator register port and pins.
// Assumes binding to fccg_top; sees only its ports.
module fccg_top_chk (
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr_stb,
  input wire logic        i_rd_stb,
  input wire logic [15:0] o_rdata,
  input wire logic        o_gen_pin_zero,
  input wire logic        o_gen_pin_one,
  input wire logic        o_gen_pin_two,
  input wire logic        o_gen_pin_three
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // Write then read of one offset returns what was stored
  prescale_rdbk_a: assert property (
    i_wr_stb && i_addr == 8'h19 && i_wdata[7:0] != 8'h00
    ##1 i_rd_stb && !i_wr_stb && i_addr == 8'h19
    |=> o_rdata == {8'h00, $past(i_wdata[7:0], 2)})
    else $error("prescale readback wrong");
  time_rdbk_a: assert property (
    i_wr_stb && i_addr == 8'h21 ##1 i_rd_stb && !i_wr_stb && i_addr == 8'h21
    |=> o_rdata == $past(i_wdata, 2))
    else $error("time readback wrong");
  phase_rdbk_a: assert property (
    i_wr_stb && i_addr == 8'h27 ##1 i_rd_stb && !i_wr_stb && i_addr == 8'h27
    |=> o_rdata == {8'h00, $past(i_wdata[7:0], 2)})
    else $error("phase readback wrong");
  // Enable and disable bits seen in the running field
  enable_set_a: assert property (
    i_wr_stb && i_addr == 8'h20 && i_wdata[8] && !i_wdata[0]
    ##1 i_rd_stb && !i_wr_stb && i_addr == 8'h20 |=> o_rdata[8])
    else $error("enable not taken");
  disable_wins_a: assert property (
    i_wr_stb && i_addr == 8'h20 && i_wdata[8] && i_wdata[0]
    ##1 i_rd_stb && !i_wr_stb && i_addr == 8'h20 |=> !o_rdata[8])
    else $error("disable did not win");
  // Sync presets the selected pin and wipes stored delays
  sync_preset_a: assert property (
    i_wr_stb && i_addr == 8'h25 && i_wdata[0]
    |=> o_gen_pin_zero == $past(i_wdata[8]))
    else $error("sync preset level wrong");
  phase_clear_a: assert property (
    i_wr_stb && i_addr == 8'h25 ##1 i_rd_stb && !i_wr_stb && i_addr == 8'h26
    |=> o_rdata == 16'h0000)
    else $error("phase not cleared by sync");
  // A disabled pin freezes; window kept short for the unroller
  disable_hold_a: assert property (
    i_wr_stb && i_addr == 8'h20 && i_wdata[0]
    |=> ##1 $stable(o_gen_pin_zero) [*8])
    else $error("disabled pin moved");
endmodule : fccg_top_chk

bind fccg_top fccg_top_chk i_chk (.i_core_clk, .i_sys_rst, .i_addr,
  .i_wdata, .i_wr_stb, .i_rd_stb, .o_rdata, .o_gen_pin_zero,
  .o_gen_pin_one, .o_gen_pin_two, .o_gen_pin_three);

/* bench/test_four_channel_clock_generator.sv */
// Bench: register port tasks and pin timing tests for the generator.
// Assumes fccg_top, the package and the pin watcher compile first.
module test_four_channel_clock_generator;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BASE = 4; // Short base tick keeps the run brief
  localparam logic [15:0] TIM [4] = '{16'h0302, 16'h0101, 16'h0101,
                                      16'h0003};
  logic             clk;
  logic             rst;
  logic [7:0]       addr;
  logic [15:0]      wdata;
  logic             wr;
  logic             rd;
  logic [15:0]      rdata;
  logic [3:0]       pins;
  logic             mark;
  logic             lvl;
  logic [3:0][15:0] hi;
  logic [3:0][15:0] lo;
  logic [3:0][15:0] first;
  int               miscompares;
  int               num_checks;

  fccg_top #(.NUM_CH(4), .BASE_CYCLES(BASE)) i_dut (.i_core_clk(clk),
    .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr_stb(wr),
    .i_rd_stb(rd), .o_rdata(rdata), .o_gen_pin_zero(pins[0]),
    .o_gen_pin_one(pins[1]), .o_gen_pin_two(pins[2]),
    .o_gen_pin_three(pins[3]));
  fccg_pin_watch i_watch (.i_core_clk(clk), .i_mark(mark), .i_pins(pins),
    .o_high(hi), .o_low(lo), .o_first(first));

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Expected phase length: zero counts as one unit
  function automatic logic [15:0] wid(input logic [7:0] t, input int ps);
    return 16'(BASE * ps * ((t == 8'h00) ? 1 : int'(t)));
  endfunction : wid

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Callers enter just after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp,
                        input string what);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : rd_reg

  task automatic sync(input logic [15:0] d);
    mark <= 1'b1;
    wr_reg(8'h25, d);
    mark <= 1'b0;
  endtask : sync

  task automatic close_out;
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("Error watchdog expected end seen hang");
    close_out();
  end

  initial begin
    {rst, addr, wdata, wr, rd, mark} = {1'b1, 8'h00, 16'h0000, 3'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(8'h19, 16'h000A, "prescale");
    wr_reg(8'h19, 16'h0001);
    rd_reg(8'h19, 16'h0001, "prescale");
    $display("Test prescale default done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'(8'h21 + i), TIM[i]);
      rd_reg(8'(8'h21 + i), TIM[i], "times");
    end
    wr_reg(8'h27, 16'h0003);
    rd_reg(8'h27, 16'h0003, "phase");
    sync(16'h0F0F);
    #1 chk("preset", 16'h000F, {12'h000, pins});
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'(8'h26 + i), 16'h0000, "clear");
    end
    repeat (200) @(posedge clk);
    #1;
    chk("period", wid(8'h01, 1) + wid(8'h01, 1), hi[1] + lo[1]);
    for (int i = 0; i < 4; i++) begin
      chk("high", wid(TIM[i][7:0], 1), hi[i]);
      chk("low", wid(TIM[i][15:8], 1), lo[i]);
    end
    chk("delay", 16'(BASE * 3), first[1] - first[2]);
    $display("Test timing and sync done");
    wr_reg(8'h19, 16'h0002);
    rd_reg(8'h19, 16'h0002, "prescale");
    sync(16'h0001);
    repeat (200) @(posedge clk);
    #1;
    chk("scaled high", wid(8'h02, 2), hi[0]);
    chk("scaled low", wid(8'h03, 2), lo[0]);
    wr_reg(8'h19, 16'h0000);
    rd_reg(8'h19, 16'h0002, "refused");
    rd_reg(8'h2A, 16'h0003, "status");
    wr_reg(8'h2A, 16'h0003);
    rd_reg(8'h2A, 16'h0000, "status");
    $display("Test prescale range done");
    wr_reg(8'h20, 16'h0101);
    rd_reg(8'h20, 16'h0E00, "running");
    lvl = pins[0];
    repeat (40) @(posedge clk);
    #1;
    chk("hold", {15'h0000, lvl}, {15'h0000, pins[0]});
    wr_reg(8'h20, 16'h0100);
    rd_reg(8'h20, 16'h0F00, "running");
    wr_reg(8'h20, 16'h000F);
    rd_reg(8'h20, 16'h0000, "running");
    repeat (12) @(posedge clk);
    $display("Test enable and disable done");
    close_out();
  end
endmodule : test_four_channel_clock_generator

/* hdl/fccg_chan.sv */
// One generator channel: phase delay, then high and low times in units.
// Assumes i_unit_tick is a one-cycle pulse once per time unit.
`include "fccg_map.svh"

module fccg_chan (
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_unit_tick,
  input  wire logic             i_start,
  input  wire logic             i_stop,
  input  wire logic             i_sync,
  input  wire logic             i_sync_level,
  input  wire fccg_pkg::fccg_byte_t i_phase,
  input  wire fccg_pkg::fccg_byte_t i_high_time,
  input  wire fccg_pkg::fccg_byte_t i_low_time,
  output logic                  o_level,
  output fccg_pkg::fccg_state_t o_state
);

  fccg_pkg::fccg_state_t state_reg;
  fccg_pkg::fccg_byte_t  cnt_reg;
  fccg_pkg::fccg_byte_t  delay_reg;
  logic                  level_reg;
  logic                  delay_done;
  logic                  phase_done;

  // A zero length still lasts one unit, so a pin never sticks
  function automatic logic reached(input fccg_pkg::fccg_byte_t cnt,
                                   input fccg_pkg::fccg_byte_t len);
    logic [8:0] need;
    need = (len == `FCCG_TIME_RST) ? 9'h001 : {1'b0, len};
    reached = (({1'b0, cnt} + 9'h001) >= need);
  endfunction : reached

  // End of the phase delay and of the current high or low phase
  assign delay_done = (delay_reg == `FCCG_PHASE_RST) |
                      (i_unit_tick & reached(cnt_reg, delay_reg));
  assign phase_done = i_unit_tick &
                      reached(cnt_reg, level_reg ? i_high_time
                                                 : i_low_time);

  // Run state; sync outranks stop, stop outranks start
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_reg <= fccg_pkg::FCCG_ST_STOPPED;
    end else if (i_sync) begin
      state_reg <= fccg_pkg::FCCG_ST_DELAY;
    end else if (i_stop) begin
      state_reg <= fccg_pkg::FCCG_ST_STOPPED;
    end else begin
      unique case (state_reg)
        fccg_pkg::FCCG_ST_STOPPED: begin
          if (i_start) begin
            state_reg <= fccg_pkg::FCCG_ST_RUN;
          end
        end
        fccg_pkg::FCCG_ST_DELAY: begin
          if (delay_done) begin
            state_reg <= fccg_pkg::FCCG_ST_RUN;
          end
        end
        fccg_pkg::FCCG_ST_RUN: begin
          state_reg <= fccg_pkg::FCCG_ST_RUN;
        end
        default: begin
          state_reg <= fccg_pkg::FCCG_ST_STOPPED;
        end
      endcase
    end
  end

  // Delay latched at sync, since the shared delay store is wiped then
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      delay_reg <= `FCCG_PHASE_RST;
    end else if (i_sync) begin
      delay_reg <= i_phase;
    end
  end

  // Unit counter restarts on every phase boundary
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= `FCCG_TIME_RST;
    end else if (i_sync || (i_start && state_reg ==
                            fccg_pkg::FCCG_ST_STOPPED)) begin
      cnt_reg <= `FCCG_TIME_RST;
    end else if (state_reg == fccg_pkg::FCCG_ST_DELAY && delay_done) begin
      cnt_reg <= `FCCG_TIME_RST;
    end else if (state_reg == fccg_pkg::FCCG_ST_RUN && phase_done) begin
      cnt_reg <= `FCCG_TIME_RST;
    end else if (i_unit_tick && state_reg != fccg_pkg::FCCG_ST_STOPPED) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Pin level: preset at sync, held while stopped, toggled in run
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      level_reg <= 1'b0;
    end else if (i_sync) begin
      level_reg <= i_sync_level;
    end else if (!i_stop && state_reg == fccg_pkg::FCCG_ST_RUN &&
                 phase_done) begin
      level_reg <= ~level_reg;
    end
  end

  assign o_level = level_reg;
  assign o_state = state_reg;

endmodule : fccg_chan

/* hdl/fccg_map.svh */
// Register offsets, reset values and timing constants of the generator.
// Assumes inclusion by bare name from the design files only.
`ifndef FCCG_MAP_SVH
`define FCCG_MAP_SVH

// Command offsets on the register port
`define FCCG_ADDR_PRESCALE   8'h19
`define FCCG_ADDR_ENABLE     8'h20
`define FCCG_ADDR_TIME_BASE  8'h21
`define FCCG_ADDR_SYNC       8'h25
`define FCCG_ADDR_PHASE_BASE 8'h26
`define FCCG_ADDR_STATUS     8'h2A
`define FCCG_ADDR_LEVELS     8'h2B

// Field layout of a command word
`define FCCG_LSB_LO     0
`define FCCG_LSB_HI     7
`define FCCG_MSB_LO     8
`define FCCG_MSB_HI     15
`define FCCG_NIB_HI     3

// Reset values and the prescaler minimum
`define FCCG_PRESCALE_RST 8'h0A
`define FCCG_PRESCALE_MIN 8'h01
`define FCCG_TIME_RST     8'h00
`define FCCG_PHASE_RST    8'h00

// Timebase: one base tick per millisecond, prescaler scales it up
`define FCCG_CLK_HZ       40000000
`define FCCG_BASE_TIME_US 1000
`define FCCG_US_PER_S     1000000

// Status word bit positions
`define FCCG_STAT_REJECT  0
`define FCCG_STAT_SYNCED  1

`endif

/* hdl/fccg_pkg.sv */
// Types shared by the clock generator top and its channel.
// Assumes nothing beyond a SystemVerilog compiler.
package fccg_pkg;

  // Run state of one generator channel
  typedef enum logic [1:0] {
    FCCG_ST_STOPPED,
    FCCG_ST_DELAY,
    FCCG_ST_RUN
  } fccg_state_t;

  typedef logic [7:0] fccg_byte_t;

endpackage : fccg_pkg

/* hdl/fccg_top.sv */
// Four-channel clock generator driving the low port pins.
// Assumes a one-cycle register port master synchronous to i_core_clk.
`include "fccg_map.svh"

module fccg_top #(
  parameter int NUM_CH      = 4,
  parameter int BASE_CYCLES = `FCCG_CLK_HZ / `FCCG_US_PER_S *
                              `FCCG_BASE_TIME_US
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  output logic      [15:0] o_rdata,
  output logic             o_gen_pin_zero,
  output logic             o_gen_pin_one,
  output logic             o_gen_pin_two,
  output logic             o_gen_pin_three
);

  localparam int CW = $clog2(BASE_CYCLES);
  localparam logic [CW-1:0] BASE_LAST = CW'(BASE_CYCLES - 1);

  fccg_pkg::fccg_byte_t  prescale_reg;
  fccg_pkg::fccg_byte_t  pre_cnt_reg;
  logic [CW-1:0]         base_cnt_reg;
  logic                  base_tick;
  logic                  unit_tick;
  fccg_pkg::fccg_byte_t  high_reg [NUM_CH];
  fccg_pkg::fccg_byte_t  low_reg  [NUM_CH];
  fccg_pkg::fccg_byte_t  phase_reg[NUM_CH];
  logic                  reject_reg;
  logic                  synced_reg;
  logic [15:0]           rdata_reg;
  logic [15:0]           rdata_next;
  logic                  wr_prescale;
  logic                  wr_enable;
  logic                  wr_sync;
  logic                  wr_status;
  logic                  wr_time;
  logic                  wr_phase;
  logic [1:0]            time_idx;
  logic [1:0]            phase_idx;
  logic [NUM_CH-1:0]     start_vec;
  logic [NUM_CH-1:0]     stop_vec;
  logic [NUM_CH-1:0]     sync_vec;
  logic [NUM_CH-1:0]     level_vec;
  logic [NUM_CH-1:0]     run_vec;
  fccg_pkg::fccg_state_t state_vec[NUM_CH];
  fccg_pkg::fccg_byte_t  lsb;
  fccg_pkg::fccg_byte_t  msb;

  // True when addr falls in the four-code window starting at base
  function automatic logic in_window(input logic [7:0] addr,
                                     input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    in_window = (addr >= base) && (diff < 8'(NUM_CH));
  endfunction : in_window

  // Channel index of addr inside the window starting at base
  function automatic logic [1:0] win_index(input logic [7:0] addr,
                                           input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    win_index = diff[1:0];
  endfunction : win_index

  // Command word split into its two data bytes
  assign lsb = i_wdata[`FCCG_LSB_HI:`FCCG_LSB_LO];
  assign msb = i_wdata[`FCCG_MSB_HI:`FCCG_MSB_LO];

  // Write decode
  assign wr_prescale = i_wr_stb && (i_addr == `FCCG_ADDR_PRESCALE);
  assign wr_enable   = i_wr_stb && (i_addr == `FCCG_ADDR_ENABLE);
  assign wr_sync     = i_wr_stb && (i_addr == `FCCG_ADDR_SYNC);
  assign wr_status   = i_wr_stb && (i_addr == `FCCG_ADDR_STATUS);
  assign wr_time     = i_wr_stb &&
                       in_window(i_addr, `FCCG_ADDR_TIME_BASE);
  assign wr_phase    = i_wr_stb &&
                       in_window(i_addr, `FCCG_ADDR_PHASE_BASE);
  assign time_idx    = win_index(i_addr, `FCCG_ADDR_TIME_BASE);
  assign phase_idx   = win_index(i_addr, `FCCG_ADDR_PHASE_BASE);

  // Per-channel command pulses from the nibbles of the command word
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      stop_vec[i]  = wr_enable && lsb[i];
      start_vec[i] = wr_enable && msb[i] && !lsb[i];
      sync_vec[i]  = wr_sync && lsb[i];
    end
  end

  // Global prescaler; zero is refused and the old value kept
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      prescale_reg <= `FCCG_PRESCALE_RST;
    end else if (wr_prescale && lsb >= `FCCG_PRESCALE_MIN) begin
      prescale_reg <= lsb;
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      reject_reg <= 1'b0;
    end else if (wr_prescale && lsb < `FCCG_PRESCALE_MIN) begin
      reject_reg <= 1'b1;
    end else if (wr_status && lsb[`FCCG_STAT_REJECT]) begin
      reject_reg <= 1'b0;
    end
  end

  // Sticky flag showing a sync has run since it was last cleared
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      synced_reg <= 1'b0;
    end else if (wr_sync) begin
      synced_reg <= 1'b1;
    end else if (wr_status && lsb[`FCCG_STAT_SYNCED]) begin
      synced_reg <= 1'b0;
    end
  end

  // Base tick; restarted by sync so every channel starts in step
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || wr_sync) begin
      base_cnt_reg <= '0;
    end else if (base_cnt_reg == BASE_LAST) begin
      base_cnt_reg <= '0;
    end else begin
      base_cnt_reg <= base_cnt_reg + CW'(1);
    end
  end

  assign base_tick = (base_cnt_reg == BASE_LAST);

  // Unit tick every prescale base ticks; larger value, slower clocks
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || wr_sync) begin
      pre_cnt_reg <= `FCCG_PHASE_RST;
    end else if (base_tick) begin
      if (pre_cnt_reg + 8'h01 >= prescale_reg) begin
        pre_cnt_reg <= `FCCG_PHASE_RST;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 8'h01;
      end
    end
  end

  // Unit length sets the period span reachable with 8-bit times
  assign unit_tick = base_tick &&
                     (pre_cnt_reg + 8'h01 >= prescale_reg);

  // High and low times; a change also sets the length of the phase already in progress
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        high_reg[i] <= `FCCG_TIME_RST;
        low_reg[i]  <= `FCCG_TIME_RST;
      end
    end else if (wr_time) begin
      high_reg[time_idx] <= lsb;
      low_reg[time_idx]  <= msb;
    end
  end

  // Phase delays, wiped by every sync after the selected channels latch them
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        phase_reg[i] <= `FCCG_PHASE_RST;
      end
    end else if (wr_sync) begin
      for (int i = 0; i < NUM_CH; i++) begin
        phase_reg[i] <= `FCCG_PHASE_RST;
      end
    end else if (wr_phase) begin
      phase_reg[phase_idx] <= lsb;
    end
  end

  // The generator channels
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    fccg_chan u_chan (
      .i_core_clk   (i_core_clk),
      .i_sys_rst    (i_sys_rst),
      .i_unit_tick  (unit_tick),
      .i_start      (start_vec[g]),
      .i_stop       (stop_vec[g]),
      .i_sync       (sync_vec[g]),
      .i_sync_level (msb[g]),
      .i_phase      (phase_reg[g]),
      .i_high_time  (high_reg[g]),
      .i_low_time   (low_reg[g]),
      .o_level      (level_vec[g]),
      .o_state      (state_vec[g])
    );
    assign run_vec[g] = (state_vec[g] != fccg_pkg::FCCG_ST_STOPPED);
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata_next = 16'h0000;
    if (i_addr == `FCCG_ADDR_PRESCALE) begin
      rdata_next = {8'h00, prescale_reg};
    end else if (i_addr == `FCCG_ADDR_ENABLE) begin
      rdata_next = {4'h0, run_vec, 8'h00};
    end else if (in_window(i_addr, `FCCG_ADDR_TIME_BASE)) begin
      rdata_next = {low_reg[time_idx], high_reg[time_idx]};
    end else if (in_window(i_addr, `FCCG_ADDR_PHASE_BASE)) begin
      rdata_next = {8'h00, phase_reg[phase_idx]};
    end else if (i_addr == `FCCG_ADDR_STATUS) begin
      rdata_next = {14'h0000, synced_reg, reject_reg};
    end else if (i_addr == `FCCG_ADDR_LEVELS) begin
      rdata_next = {4'h0, run_vec, 4'h0, level_vec};
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_reg <= 16'h0000;
    end else if (i_rd_stb) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // Outputs; each pin comes straight from its channel's level flop
  assign o_rdata         = rdata_reg;
  assign o_gen_pin_zero  = level_vec[0];
  assign o_gen_pin_one   = level_vec[1];
  assign o_gen_pin_two   = level_vec[2];
  assign o_gen_pin_three = level_vec[3];

endmodule : fccg_top
